// ===== common/crsc_defines.vh
/*
 * constants for the core register-state block: register offsets on the
 * AXI4-Lite slave, flag positions, reset values, vectors, stop recovery.
 * assumes inclusion by bare name from verilog/ sources.
 */
`ifndef CRSC_DEFINES_VH
`define CRSC_DEFINES_VH

// register byte offsets
`define CRSC_OFF_ACC      8'h00
`define CRSC_OFF_IDX      8'h04
`define CRSC_OFF_SP       8'h08
`define CRSC_OFF_PC       8'h0C
`define CRSC_OFF_FLAGS    8'h10
`define CRSC_OFF_OP       8'h14
`define CRSC_OFF_OPERAND  8'h18
`define CRSC_OFF_CTRL     8'h1C
`define CRSC_OFF_STATUS   8'h20

// condition flag bit positions
`define CRSC_F_C          0
`define CRSC_F_Z          1
`define CRSC_F_N          2
`define CRSC_F_I          3
`define CRSC_F_H          4
`define CRSC_F_V          7
`define CRSC_FLAGS_ONES   8'h60
`define CRSC_FLAGS_RESET  8'h08

// reset values and vectors
`define CRSC_SP_RESET     16'h00FF
`define CRSC_SP_LOW_FF    8'hFF
`define CRSC_VEC_RESET    16'hFFFE
`define CRSC_VEC_BRK      16'hFFFC
`define CRSC_VEC_BRK_MON  16'hFEFC
`define CRSC_VEC_IRQ      16'hFFFA
`define CRSC_SWI_OPCODE   8'h83

// operation codes written to the op register
`define CRSC_OP_NONE      4'h0
`define CRSC_OP_ADD       4'h1
`define CRSC_OP_ADC       4'h2
`define CRSC_OP_SUB       4'h3
`define CRSC_OP_LOGIC     4'h4
`define CRSC_OP_LDIDX     4'h5
`define CRSC_OP_PUSH      4'h6
`define CRSC_OP_PULL      4'h7
`define CRSC_OP_SPRST     4'h8
`define CRSC_OP_JUMP      4'h9
`define CRSC_OP_CLI       4'hA
`define CRSC_OP_RTI       4'hB
`define CRSC_OP_WAIT      4'hC
`define CRSC_OP_STOP      4'hD
`define CRSC_OP_FETCH     4'hE
`define CRSC_OP_SHIFT     4'hF

// stop recovery, crystal clock cycles
`define CRSC_REC_LONG     13'd4096
`define CRSC_REC_SHORT    13'd32
`define CRSC_REC_W        13

// axi responses
`define CRSC_RESP_OKAY    2'b00
`define CRSC_RESP_SLVERR  2'b10

`endif

// ===== verif/crsc_checker.sv
/* checker for the core register-state block: bus handshakes, break entry,
   clock gating and stop recovery. assumes binding onto crsc_core_regs. */
`timescale 1ns/10ps
module crsc_checker (
  // clock and reset
  input wire        clk_sys_i,
  input wire        nrst_i,
  // bus handshakes
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // core side
  input wire [3:0]  irq_req_i,
  input wire        brk_match_last_i,
  input wire        crystal_clock_tick_i,
  input wire        core_clk_en_o,
  input wire        brk_ack_o,
  input wire [7:0]  instr_reg_o
);
  reg [12:0] tick_cnt_reg;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  //////////////////////////////////////////////////////////////////////////
  // ticks while gated with a wake request; cleared whenever the core runs
  always @(posedge clk_sys_i) begin
    if (!nrst_i || core_clk_en_o)
      tick_cnt_reg <= 13'h0000;
    else if (crystal_clock_tick_i && irq_req_i != 4'h0)
      tick_cnt_reg <= tick_cnt_reg + 13'h0001;
  end
  //////////////////////////////////////////////////////////////////////////
  AST_BRK_OPCODE: assert property (brk_ack_o |-> ##[0:1] instr_reg_o == 8'h83)
    else $error("break entry without the software interrupt opcode");
  AST_ACK_PULSE: assert property (brk_ack_o |=> !brk_ack_o)
    else $error("break acknowledge longer than one cycle");
  AST_MATCH_NOW: assert property ($rose(brk_match_last_i) && core_clk_en_o && !brk_ack_o
    |-> ##[1:2] brk_ack_o) else $error("match on last cycle did not start break at once");
  AST_GATED_HOLD: assert property (!core_clk_en_o && irq_req_i == 4'h0 |=> !core_clk_en_o)
    else $error("core clock restarted without a wake request");
  AST_STOP_DELAY: assert property ($rose(core_clk_en_o)
    |-> tick_cnt_reg < 13'd2 || tick_cnt_reg >= 13'd31) else $error("stop recovery too short");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before it was taken");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before it was taken");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property ($rose(s_axi_awready) |-> ##[1:4] s_axi_bvalid)
    else $error("write answer late");
endmodule

// ===== verif/crsc_far_side.sv
/* model of the far side: interrupt sources, break module, crystal tick.
   assumes the bench commands requests and feeds back the break acknowledge. */
`timescale 1ns/10ps
module crsc_far_side (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       nrst_i,
  // commands from the bench
  input  wire [3:0] irq_set_i,
  input  wire       brk_go_i,
  input  wire       brk_hold_i,
  input  wire       brk_ack_i,
  // lines into the core
  output wire [3:0] irq_req_o,
  output reg        brk_req_o,
  output reg        tick_o
);
  reg ack_seen_reg;
  //////////////////////////////////////////////////////////////////////////
  // level sources stay up until the bench drops them
  assign irq_req_o = irq_set_i;
  // request held until entry is acknowledged; hold breaks that on purpose
  always @(posedge clk_sys_i) begin
    if (!nrst_i || brk_go_i)
      ack_seen_reg <= 1'b0;
    else if (brk_ack_i)
      ack_seen_reg <= 1'b1;
    if (!nrst_i)
      brk_req_o <= 1'b0;
    else if (brk_go_i)
      brk_req_o <= 1'b1;
    else if ((brk_ack_i || ack_seen_reg) && !brk_hold_i)
      brk_req_o <= 1'b0;
  end
  // crystal runs at half the system rate, a tick every other cycle
  always @(posedge clk_sys_i) begin
    tick_o <= nrst_i ? !tick_o : 1'b0;
  end
endmodule

// ===== verif/test_crsc_core_regs.sv
/* self-checking bench for crsc_core_regs: register map, flags, stack,
   interrupts, wait, break, stop. assumes the far-side model and checker. */
`timescale 1ns/10ps
`include "crsc_defines.vh"
`define CHK(what, exp, got) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) begin \
      error_cnt = error_cnt + 1; \
      $display("unexpected %0s expected %h seen %h", what, exp, got); \
    end \
  end
module test_crsc_core_regs;
  reg        clk_sys_i, nrst_i = 1'b0, brk_go = 1'b0, brk_hold = 1'b0;
  reg [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h00000000, rd_data;
  reg        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, brk_match_last_i = 1'b0;
  reg        monitor_mode_i = 1'b0;
  reg [3:0]  irq_set = 4'h0;
  reg [1:0]  wr_resp, rd_resp;
  wire [3:0] s_axi_wstrb = 4'hF, irq_req_i;
  wire [31:0] s_axi_rdata;
  wire [7:0] instr_reg_o;
  wire [1:0] s_axi_bresp, s_axi_rresp, irq_taken_o;
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire       brk_req_i, crystal_clock_tick_i, core_clk_en_o, brk_ack_o;
  integer    error_cnt = 0, check_count = 0, cyc = 0, m, t;
  //////////////////////////////////////////////////////////////////////////
  crsc_core_regs dut_u (.clk_sys_i, .nrst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq_req_i, .brk_req_i, .brk_match_last_i, .monitor_mode_i,
    .crystal_clock_tick_i, .core_clk_en_o, .brk_ack_o, .instr_reg_o, .irq_taken_o);
  crsc_far_side far_u (.clk_sys_i, .nrst_i, .irq_set_i(irq_set), .brk_go_i(brk_go),
    .brk_hold_i(brk_hold), .brk_ack_i(brk_ack_o), .irq_req_o(irq_req_i),
    .brk_req_o(brk_req_i), .tick_o(crystal_clock_tick_i));
  // clock and a hang guard well above the long stop recovery
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // both write channels offered together, each released when taken
  task axi_wr(input [7:0] a, input [31:0] d);
    reg done;
    begin
      @(posedge clk_sys_i);
      done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!done) begin
        @(posedge clk_sys_i);
        if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
        if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid === 1'b1) begin
          done = 1'b1;
          wr_resp = s_axi_bresp;
          s_axi_bready <= 1'b0;
        end
      end
    end
  endtask
  task axi_rd(input [7:0] a);
    reg done;
    begin
      @(posedge clk_sys_i);
      done = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!done) begin
        @(posedge clk_sys_i);
        if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid === 1'b1) begin
          done = 1'b1;
          rd_data = s_axi_rdata;
          rd_resp = s_axi_rresp;
          s_axi_rready <= 1'b0;
        end
      end
    end
  endtask
  task rd_chk(input [7:0] a, input [127:0] what, input [31:0] exp, input [31:0] msk = 32'hFFFFFFFF);
    begin
      axi_rd(a);
      `CHK(what, exp, rd_data & msk)
    end
  endtask
  task do_op(input [3:0] op, input [15:0] arg);
    begin
      axi_wr(`CRSC_OFF_OPERAND, {16'h0000, arg});
      axi_wr(`CRSC_OFF_OP, {28'h0000000, op});
    end
  endtask
  task give_verdict;
    begin
      $display("comparisons %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence; each step leans on the state the previous one left
  initial begin
    repeat (2) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd_chk(`CRSC_OFF_SP, "sp", 32'h000000FF);
    rd_chk(`CRSC_OFF_PC, "pc", 32'h0000FFFE);
    rd_chk(`CRSC_OFF_FLAGS, "flags", 32'h00000068);
    axi_rd(8'h40);
    `CHK("rresp", `CRSC_RESP_SLVERR, rd_resp)
    axi_wr(8'h44, 32'h00000001);
    `CHK("bresp", `CRSC_RESP_SLVERR, wr_resp)
    $display("test reset and map done");
    do_op(`CRSC_OP_LOGIC, 16'h0000);
    rd_chk(`CRSC_OFF_FLAGS, "flags and", 32'h0000006A);
    do_op(`CRSC_OP_ADD, 16'h0088);
    rd_chk(`CRSC_OFF_FLAGS, "flags add", 32'h0000006C);
    do_op(`CRSC_OP_ADD, 16'h0088);
    rd_chk(`CRSC_OFF_FLAGS, "flags ovf", 32'h000000F9);
    rd_chk(`CRSC_OFF_ACC, "acc", 32'h00000010);
    do_op(`CRSC_OP_SUB, 16'h0020);
    rd_chk(`CRSC_OFF_FLAGS, "flags sub", 32'h00000005, 32'h00000087);
    do_op(`CRSC_OP_ADC, 16'h000F);
    rd_chk(`CRSC_OFF_FLAGS, "flags adc", 32'h0000007B);
    do_op(`CRSC_OP_SHIFT, 16'h0000);
    rd_chk(`CRSC_OFF_FLAGS, "flags shl", 32'h0000007A);
    $display("test flags done");
    do_op(`CRSC_OP_PUSH, 16'h0000);
    rd_chk(`CRSC_OFF_SP, "sp push", 32'h000000FE);
    do_op(`CRSC_OP_PULL, 16'h0000);
    do_op(`CRSC_OP_PULL, 16'h0000);
    rd_chk(`CRSC_OFF_SP, "sp pull", 32'h00000100);
    do_op(`CRSC_OP_SPRST, 16'h0000);
    rd_chk(`CRSC_OFF_SP, "sp low", 32'h000001FF);
    do_op(`CRSC_OP_LDIDX, 16'hA55A);
    rd_chk(`CRSC_OFF_IDX, "index", 32'h0000A55A);
    do_op(`CRSC_OP_JUMP, 16'h1234);
    do_op(`CRSC_OP_FETCH, 16'h0000);
    rd_chk(`CRSC_OFF_PC, "pc", 32'h00001235);
    $display("test stack and pc done");
    irq_set <= 4'b0110;
    do_op(`CRSC_OP_NONE, 16'h0000);
    rd_chk(`CRSC_OFF_SP, "sp masked", 32'h000001FF);
    do_op(`CRSC_OP_CLI, 16'h0000);
    do_op(`CRSC_OP_NONE, 16'h0000);
    rd_chk(`CRSC_OFF_SP, "sp entry", 32'h000001FA);
    rd_chk(`CRSC_OFF_PC, "irq pc", 32'h0000FFF8);
    rd_chk(`CRSC_OFF_FLAGS, "mask entry", 32'h00000008, 32'h00000008);
    `CHK("irq index", 2'd1, irq_taken_o)
    irq_set <= 4'h0;
    do_op(`CRSC_OP_RTI, 16'h0000);
    rd_chk(`CRSC_OFF_FLAGS, "flags rti", 32'h00000060);
    rd_chk(`CRSC_OFF_SP, "sp rti", 32'h000001FF);
    do_op(`CRSC_OP_WAIT, 16'h0000);
    rd_chk(`CRSC_OFF_STATUS, "wait state", 32'h00000002, 32'h00000007);
    `CHK("clk off", 1'b0, core_clk_en_o)
    irq_set <= 4'b0001;
    repeat (3) @(posedge clk_sys_i);
    `CHK("clk wake", 1'b1, core_clk_en_o)
    rd_chk(`CRSC_OFF_FLAGS, "mask wake", 32'h00000000, 32'h00000008);
    irq_set <= 4'h0;
    $display("test interrupts and wait done");
    // break by request and held request, then by last-cycle match in monitor mode
    for (m = 0; m < 2; m = m + 1) begin
      @(posedge clk_sys_i);
      monitor_mode_i <= m[0];
      brk_go <= ~m[0];
      brk_hold <= ~m[0];
      brk_match_last_i <= m[0];
      @(posedge clk_sys_i);
      brk_go <= 1'b0;
      brk_match_last_i <= 1'b0;
      if (m == 0) do_op(`CRSC_OP_NONE, 16'h0000);
      repeat (2) @(posedge clk_sys_i);
      `CHK("opcode", 8'h83, instr_reg_o)
      rd_chk(`CRSC_OFF_PC, "brk pc", m ? 32'h0000FEFC : 32'h0000FFFC);
      do_op(`CRSC_OP_RTI, 16'h0000);
      rd_chk(`CRSC_OFF_STATUS, "held brk", {28'h0, ~m[0], 3'b000}, 32'h00000008);
      brk_hold <= 1'b0;
      do_op(`CRSC_OP_RTI, 16'h0000);
      rd_chk(`CRSC_OFF_STATUS, "brk end", 32'h00000000, 32'h00000008);
    end
    $display("test break done");
    // stop with short recovery first, then the long one
    for (m = 0; m < 2; m = m + 1) begin
      axi_wr(`CRSC_OFF_CTRL, (m == 0) ? 32'h00000001 : 32'h00000000);
      do_op(`CRSC_OP_STOP, 16'h0000);
      rd_chk(`CRSC_OFF_FLAGS, "mask stop", 32'h00000000, 32'h00000008);
      `CHK("clk stop", 1'b0, core_clk_en_o)
      irq_set <= 4'b0010;
      t = 0;
      while (core_clk_en_o !== 1'b1) begin
        @(posedge clk_sys_i);
        if (crystal_clock_tick_i) t = t + 1;
      end
      t = t - ((m == 0) ? `CRSC_REC_SHORT : `CRSC_REC_LONG);
      `CHK("recovery", 1'b1, t >= -1 && t <= 1)
      irq_set <= 4'h0;
    end
    $display("test stop done");
    give_verdict;
  end
endmodule
bind crsc_core_regs crsc_checker chk_u (.clk_sys_i, .nrst_i, .s_axi_awready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .irq_req_i, .brk_match_last_i, .crystal_clock_tick_i, .core_clk_en_o, .brk_ack_o,
  .instr_reg_o);

// ===== verilog/crsc_core_regs.v
/*
 * architectural register state of an 8-bit core with flag generation,
 * mask handling, wait/stop clock gating and break entry/exit.
 * assumes a synchronous AXI4-Lite master and a crystal clock tick input.
 */
`timescale 1ns/10ps
`include "crsc_defines.vh"
// Overview of operation
// - 8-bit accumulator holds operands and receives arithmetic and logic results.
// - 16-bit index pair from upper and lower bytes forms operand addresses.
// - stack pointer resets to 00FF; stack reset op sets only low byte FF.
// - stack pointer addresses next free slot; push decrements, pull increments.
// - program counter increments per fetch; jumps and interrupts load it.
// - reset loads program counter with the vector address FFFE itself; no vector bytes are read.
// - flag register holds mask and five flags; bits 6 and 5 read one.
// - overflow flag set on two's-complement overflow, cleared otherwise.
// - half-carry set on carry from bit 3 into bit 4 during adds.
// - mask blocks interrupts; set after stacking, before vector fetch.
// - interrupt entry does not stack the upper index byte.
// - return restores mask from stack; highest pending request served first.
// - mask set after reset; only clear-mask op, return, wait or stop clears it.
// - negative flag follows bit 7 of the result.
// - zero flag set when result is 00, cleared otherwise.
// - carry set on carry out of bit 7 or borrow; shifts also set it.
// - wait clears mask, gates core clock; interrupt wake keeps mask clear.
// - stop clears mask, gates clock; wake waits oscillator stabilisation.
// - break loads software-interrupt opcode and vector FFFC or FEFC in monitor.
// - break starts after current instruction, or at once on final cycle.
// - return in break routine ends break only once request is dropped.
// - stop recovery is 4096 crystal cycles, or 32 with short option.
module crsc_core_regs (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        nrst_i,
  // axi4-lite write address and data
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // interrupt sources, break module, crystal clock tick
  input  wire [3:0]  irq_req_i,
  input  wire        brk_req_i,
  input  wire        brk_match_last_i,
  input  wire        monitor_mode_i,
  input  wire        crystal_clock_tick_i,
  // core state outputs
  output reg         core_clk_en_o,
  output reg         brk_ack_o,
  output reg  [7:0]  instr_reg_o,
  output reg  [1:0]  irq_taken_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  localparam ST_RUN  = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_STOP = 3'b100;

  reg [7:0]  accumulator_reg;
  reg [15:0] index_pair_reg;
  reg [15:0] stack_pointer_reg;
  reg [15:0] program_counter_reg;
  reg [7:0]  flags_reg;
  reg [3:0]  op_reg;
  reg [15:0] operand_reg;
  reg [1:0]  ctrl_reg;          // bit0 short_recovery_option, bit1 never written, reads zero
  reg        in_break_reg;
  reg [2:0]  state_reg;
  reg [`CRSC_REC_W-1:0] rec_cnt_reg;

  // status view of flags: bits 6 and 5 are fixed at one
  wire [7:0] flags_view = flags_reg | `CRSC_FLAGS_ONES;

  // lowest-numbered request has highest priority
  function [2:0] prio_pick;
    input [3:0] req;
    begin
      if (req[0])      prio_pick = 3'b100;
      else if (req[1]) prio_pick = 3'b101;
      else if (req[2]) prio_pick = 3'b110;
      else if (req[3]) prio_pick = 3'b111;
      else             prio_pick = 3'b000;
    end
  endfunction

  // add/sub with flags: {c, h, v, result}
  function [10:0] alu_add;
    input [7:0] a;
    input [7:0] b;
    input       cin;
    input       sub;
    reg   [7:0] bb;
    reg   [8:0] s;
    reg   [4:0] lo;
    begin
      bb = sub ? ~b : b;
      s  = {1'b0, a} + {1'b0, bb} + {8'h00, (sub ? ~cin : cin)};
      lo = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, (sub ? ~cin : cin)};
      alu_add = {(sub ? ~s[8] : s[8]), lo[4], (a[7] == bb[7]) && (s[7] != a[7]), s[7:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite handshakes and decoding
  // halves wait here for each other
  reg        aw_held_reg;
  reg        w_held_reg;
  reg [7:0]  aw_addr_reg;
  reg [31:0] w_data_reg;

  // write channels accepted separately, in either order
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CRSC_RESP_OKAY;
    end else begin
      // ready follows valid; never starves a master
      s_axi_awready <= !aw_held_reg && s_axi_awvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && s_axi_wvalid && !s_axi_wready &&
                       !s_axi_bvalid;
      if (s_axi_awready && s_axi_awvalid) begin
        aw_held_reg   <= 1'b1;
        aw_addr_reg   <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_held_reg   <= 1'b1;
        w_data_reg   <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_reg > `CRSC_OFF_STATUS || aw_addr_reg[1:0] != 2'b00) ?
                        `CRSC_RESP_SLVERR : `CRSC_RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a write lands on the edge that raises its response
  wire       wr_now = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // read channel: one read at a time, answer one cycle after address
  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `CRSC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `CRSC_RESP_OKAY;
        case (s_axi_araddr)
          `CRSC_OFF_ACC:     s_axi_rdata <= {24'h000000, accumulator_reg};
          `CRSC_OFF_IDX:     s_axi_rdata <= {16'h0000, index_pair_reg};
          `CRSC_OFF_SP:      s_axi_rdata <= {16'h0000, stack_pointer_reg};
          `CRSC_OFF_PC:      s_axi_rdata <= {16'h0000, program_counter_reg};
          `CRSC_OFF_FLAGS:   s_axi_rdata <= {24'h000000, flags_view};
          `CRSC_OFF_OP:      s_axi_rdata <= {28'h0000000, op_reg};
          `CRSC_OFF_OPERAND: s_axi_rdata <= {16'h0000, operand_reg};
          `CRSC_OFF_CTRL:    s_axi_rdata <= {30'h00000000, ctrl_reg};
          `CRSC_OFF_STATUS:  s_axi_rdata <= {24'h000000, instr_reg_o[7:3] == 5'h00 ?
                                           4'h0 : 4'h1, in_break_reg, state_reg};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRSC_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // execution of one operation per write to the op register
  wire        op_wr    = wr_now && aw_addr_reg == `CRSC_OFF_OP;
  wire [3:0]  op       = w_data_reg[3:0];
  wire [10:0] sum      = alu_add(accumulator_reg, operand_reg[7:0],
                                 flags_reg[`CRSC_F_C] && op == `CRSC_OP_ADC,
                                 op == `CRSC_OP_SUB);
  wire [2:0]  pick     = prio_pick(irq_req_i);
  wire        irq_ok   = pick[2] && !flags_reg[`CRSC_F_I];
  // break pends until an instruction boundary, or now on a final-cycle match
  wire        brk_now  = (brk_req_i && op_wr) || brk_match_last_i;
  wire        rec_done = rec_cnt_reg == {`CRSC_REC_W{1'b0}};

  // recovery length chosen by option, in crystal clock ticks; the short
  // one is too brief for a crystal that was stopped
  wire [`CRSC_REC_W-1:0] rec_len = ctrl_reg[0] ? `CRSC_REC_SHORT - 13'd1 :
                   `CRSC_REC_LONG - 13'd1;

  always @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      accumulator_reg     <= 8'h00;
      index_pair_reg      <= 16'h0000;
      stack_pointer_reg   <= `CRSC_SP_RESET;
      program_counter_reg <= `CRSC_VEC_RESET;
      flags_reg           <= `CRSC_FLAGS_RESET;
      op_reg              <= `CRSC_OP_NONE;
      operand_reg         <= 16'h0000;
      ctrl_reg            <= 2'b00;
      in_break_reg        <= 1'b0;
      state_reg           <= ST_RUN;
      rec_cnt_reg         <= {`CRSC_REC_W{1'b0}};
      core_clk_en_o       <= 1'b1;
      brk_ack_o           <= 1'b0;
      instr_reg_o         <= 8'h00;
      irq_taken_o         <= 2'b00;
    end else begin
      brk_ack_o <= 1'b0;
      if (wr_now && aw_addr_reg == `CRSC_OFF_OPERAND) operand_reg <= w_data_reg[15:0];
      if (wr_now && aw_addr_reg == `CRSC_OFF_CTRL)    ctrl_reg[0] <= w_data_reg[0];
      case (state_reg)
        ST_RUN: begin
          // break outranks an interrupt
          if (brk_now && !in_break_reg) begin
            instr_reg_o         <= `CRSC_SWI_OPCODE;
            program_counter_reg <= monitor_mode_i ? `CRSC_VEC_BRK_MON : `CRSC_VEC_BRK;
            in_break_reg        <= 1'b1;
            brk_ack_o           <= 1'b1;
          end else if (irq_ok && op_wr) begin
            // registers stacked (pc, x, a, flags) without upper index
            stack_pointer_reg   <= stack_pointer_reg - 16'h0005;
            flags_reg[`CRSC_F_I] <= 1'b1;
            program_counter_reg <= `CRSC_VEC_IRQ - {13'h0000, pick[1:0], 1'b0};
            irq_taken_o         <= pick[1:0];
          end else if (op_wr) begin
            // plain operation
            op_reg <= op;
            case (op)
              `CRSC_OP_ADD, `CRSC_OP_ADC, `CRSC_OP_SUB: begin
                accumulator_reg <= sum[7:0];
                flags_reg[`CRSC_F_V] <= sum[8];
                // sub leaves half-carry
                if (op != `CRSC_OP_SUB) flags_reg[`CRSC_F_H] <= sum[9];
                flags_reg[`CRSC_F_C] <= sum[10];
                flags_reg[`CRSC_F_N] <= sum[7];
                flags_reg[`CRSC_F_Z] <= sum[7:0] == 8'h00;
              end
              `CRSC_OP_LOGIC: begin
                // and: overflow cleared
                accumulator_reg <= accumulator_reg & operand_reg[7:0];
                flags_reg[`CRSC_F_V] <= 1'b0;
                flags_reg[`CRSC_F_N] <= accumulator_reg[7] & operand_reg[7];
                flags_reg[`CRSC_F_Z] <= (accumulator_reg & operand_reg[7:0]) == 8'h00;
              end
              `CRSC_OP_SHIFT: begin
                // carry gets bit shifted out
                accumulator_reg <= {accumulator_reg[6:0], 1'b0};
                flags_reg[`CRSC_F_C] <= accumulator_reg[7];
                flags_reg[`CRSC_F_N] <= accumulator_reg[6];
                flags_reg[`CRSC_F_Z] <= accumulator_reg[6:0] == 7'h00;
                flags_reg[`CRSC_F_V] <= accumulator_reg[7] ^ accumulator_reg[6];
              end
              `CRSC_OP_LDIDX:  index_pair_reg <= operand_reg;
              `CRSC_OP_PUSH:   stack_pointer_reg <= stack_pointer_reg - 16'h0001;
              `CRSC_OP_PULL:   stack_pointer_reg <= stack_pointer_reg + 16'h0001;
              `CRSC_OP_SPRST:  stack_pointer_reg[7:0] <= `CRSC_SP_LOW_FF;
              `CRSC_OP_JUMP:   program_counter_reg <= operand_reg;
              `CRSC_OP_FETCH:  program_counter_reg <= program_counter_reg + 16'h0001;
              `CRSC_OP_CLI:    flags_reg[`CRSC_F_I] <= 1'b0;
              `CRSC_OP_RTI: begin
                // operand low byte carries the stacked flag image
                flags_reg <= operand_reg[7:0];
                stack_pointer_reg <= stack_pointer_reg + 16'h0005;
                // held request keeps the break
                if (in_break_reg && !brk_req_i) in_break_reg <= 1'b0;
              end
              // entry gates the core clock
              `CRSC_OP_WAIT: begin
                flags_reg[`CRSC_F_I] <= 1'b0;
                core_clk_en_o <= 1'b0;
                state_reg <= ST_WAIT;
              end
              `CRSC_OP_STOP: begin
                flags_reg[`CRSC_F_I] <= 1'b0;
                core_clk_en_o <= 1'b0;
                state_reg <= ST_STOP;
              end
              default: op_reg <= op;
            endcase
          end
        end

        // interrupt wakes with mask left clear
        ST_WAIT: begin
          if (pick[2]) begin
            core_clk_en_o <= 1'b1;
            state_reg <= ST_RUN;
          end
        end

        // stop: count stabilisation ticks, then restart the clock
        ST_STOP: begin
          // first wake request arms the count
          if (pick[2] && rec_done && instr_reg_o != 8'hFF) begin
            rec_cnt_reg <= rec_len;
            instr_reg_o <= 8'hFF;
          end else if (instr_reg_o == 8'hFF) begin
            // clock stays gated until the count runs out
            if (rec_done) begin
              core_clk_en_o <= 1'b1;
              instr_reg_o   <= 8'h00;
              state_reg     <= ST_RUN;
            end else if (crystal_clock_tick_i) begin
              rec_cnt_reg <= rec_cnt_reg - {{(`CRSC_REC_W-1){1'b0}}, 1'b1};
            end
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

endmodule
